// File: core/qa_answer_ref.sv
/*
 * reference answer byte lookup from question and answer byte counter.
 * assumes the default feedback answer mapping; purely combinational.
 */
`timescale 1ns/1ps

module qa_answer_ref
   import qa_wd_pkg::*;
(
   input  wire logic [3:0] question,
   input  wire logic [1:0] answer_byte_counter,
   output logic      [7:0] ref_byte
);

   // ************************************************************
   // table: {answer 3, answer 2, answer 1, answer 0} per question
   // ************************************************************
   localparam logic [15:0][31:0] ANSWER_TABLE = {
      32'h01f10efe, 32'h4ebe41b1, 32'h17e718e8, 32'h58a857a7,
      32'h8b7b8474, 32'hc434cb3b, 32'h9d6d9262, 32'hd222dd2d,
      32'h2cdc23d3, 32'h63936c9c, 32'h3aca35c5, 32'h75857a8a,
      32'ha656a959, 32'he919e616, 32'hb040bf4f, 32'hff0ff000
   };

   logic [31:0] word;

   always_comb begin
      word     = ANSWER_TABLE[question];
      ref_byte = word[{answer_byte_counter, 3'b000} +: 8];
   end

endmodule : qa_answer_ref

// File: core/qa_watchdog_answer_checker.sv
/*
 * question-and-answer watchdog checker with apb register access.
 * assumes window timing, time-out detection and self-test sequencing live outside;
 * win2_active, timeout_evt and lbist_done are synchronous to core_clk.
 */
// The placing of the registers and register access over APB were chosen for this implementation.
// Summary of operation
// - feedback select picks one of four 4-bit lfsr polynomials
// - an all-zero lfsr state steps as if it held one
// - answer byte counter starts each sequence at 11b
// - answer write at counter 11b, 10b, 01b compares, updates error, decrements
// - answer write at 00b compares, ends sequence, reloads counter to 11b
// - reference bytes follow the tabulated values per question and counter
// - good sequence: fail count down, new question, clear sequence and early flags
// - correct bytes wrongly timed: fail count up, set sequence and early flags
// - wrong byte correct timing: fail up, sequence flag set, early cleared
// - wrong byte and wrong timing: fail up, sequence and early flags set
// - time-out: fail count up, question kept, time-out flag set
// - window config write: fail count up, config changed flag set
// - time-out: sequence flag reflects earlier bytes, early flag cleared
// - after config change only config changed flag reads one
// - question counter wrap from 1111b to 0000b steps the lfsr
// - good final byte yields new question and sequence within one cycle
// - self-test completion clears question counter and lfsr
`timescale 1ns/1ps
`include "qa_wd_params.svh"

module qa_watchdog_answer_checker
   import qa_wd_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire apb_req_t   apb_req,
   output apb_rsp_t        apb_rsp,
   input  wire logic       win2_active,
   input  wire logic       timeout_evt,
   input  wire logic       lbist_done,
   output logic            seq_start,
   output logic [2:0]      fail_count,
   output logic [3:0]      question
);

   // ************************************************************
   // declarations
   // ************************************************************
   wd_state_t  st_reg;
   wd_state_t  st_next;
   logic [7:0] ref_byte;
   logic [3:0] question_now;
   logic       access;
   logic       done;
   logic       wr;
   logic       ans_wr;
   logic       cfg_wr;
   logic       final_wr;
   logic       err_now;
   logic       good;
   logic       hit;
   logic [31:0] rd_data;

   // ************************************************************
   // lfsr step
   // ************************************************************
   function automatic logic [3:0] lfsr_step(input logic [3:0] cur, input logic [1:0] sel);
      logic [3:0] eff;
      logic       fb;
      eff = (cur == `QA_LFSR_RESET) ? `QA_LFSR_ZERO_SUB : cur;
      case (sel)
         `QA_POLY_X4X3: fb = eff[3] ^ eff[2];
         `QA_POLY_X4X2: fb = eff[3] ^ eff[1];
         `QA_POLY_X3X2: fb = eff[2] ^ eff[1];
         default:       fb = eff[3] ^ eff[2] ^ eff[1];
      endcase
      return {eff[2:0], fb};
   endfunction : lfsr_step

   // ************************************************************
   // reference answer
   // ************************************************************
   assign question_now = st_reg.question_counter ^ st_reg.lfsr;

   qa_answer_ref u_ref (
      .question            (question_now),
      .answer_byte_counter (st_reg.answer_byte_counter),
      .ref_byte            (ref_byte)
   );

   // ************************************************************
   // apb decode
   // ************************************************************
   always_comb begin
      hit     = 1'b1;
      rd_data = 32'h0000_0000;
      if (apb_req.paddr == `QA_OFS_FEEDBACK) begin
         rd_data[`QA_LFSR_POLY_SELECT_MSB:`QA_LFSR_POLY_SELECT_LSB] = st_reg.lfsr_poly_select;
      end else if (apb_req.paddr == `QA_OFS_QUESTION) begin
         rd_data[3:0] = question_now;
      end else if (apb_req.paddr == `QA_OFS_ANSWER) begin
         rd_data[7:0] = st_reg.answer_write_field;
      end else if (apb_req.paddr == `QA_OFS_STATUS) begin
         rd_data[`QA_ST_EARLY]                   = st_reg.answer_early;
         rd_data[`QA_ST_TOUT]                    = st_reg.time_out;
         rd_data[`QA_ST_SEQUENCE_ERROR_FLAG]                 = st_reg.sequence_error_flag;
         rd_data[`QA_ST_CFG_CHG]                 = st_reg.window_config_changed_flag;
         rd_data[`QA_ST_ANS_ERR]                 = st_reg.answer_err;
         rd_data[`QA_ST_CNT_MSB:`QA_ST_CNT_LSB] = st_reg.answer_byte_counter;
      end else if (apb_req.paddr == `QA_OFS_FAIL) begin
         rd_data[2:0] = st_reg.watchdog_fail_counter;
      end else if (apb_req.paddr == `QA_OFS_WIN1) begin
         rd_data[7:0] = st_reg.first_window_duration_config;
      end else if (apb_req.paddr == `QA_OFS_WIN2) begin
         rd_data[7:0] = st_reg.second_window_duration_config;
      end else begin
         hit = 1'b0;
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next             = st_reg;
      st_next.seq_start   = 1'b0;
      st_next.rsp.pready  = 1'b0;
      st_next.rsp.pslverr = 1'b0;
      access   = apb_req.psel & apb_req.penable;
      done     = access & st_reg.rsp.pready;
      wr       = done & apb_req.pwrite & ~st_reg.rsp.pslverr;
      ans_wr   = wr & (apb_req.paddr == `QA_OFS_ANSWER);
      cfg_wr   = wr & ((apb_req.paddr == `QA_OFS_WIN1) | (apb_req.paddr == `QA_OFS_WIN2));
      err_now  = st_reg.answer_err | (apb_req.pwdata[7:0] != ref_byte);
      final_wr = ans_wr & (st_reg.answer_byte_counter == `QA_ANS_CNT_LAST);
      good     = final_wr & ~err_now & win2_active;

      if (access & ~st_reg.rsp.pready) begin
         st_next.rsp.pready  = 1'b1;
         st_next.rsp.pslverr = ~hit;
         if (!apb_req.pwrite) begin
            st_next.rsp.prdata = rd_data;
         end
      end

      if (wr & (apb_req.paddr == `QA_OFS_FEEDBACK)) begin
         st_next.lfsr_poly_select = apb_req.pwdata[`QA_LFSR_POLY_SELECT_MSB:`QA_LFSR_POLY_SELECT_LSB];
      end
      if (wr & (apb_req.paddr == `QA_OFS_WIN1)) begin
         st_next.first_window_duration_config = apb_req.pwdata[7:0];
      end
      if (wr & (apb_req.paddr == `QA_OFS_WIN2)) begin
         st_next.second_window_duration_config = apb_req.pwdata[7:0];
      end
      if (ans_wr) begin
         st_next.answer_write_field = apb_req.pwdata[7:0];
      end

      if (cfg_wr) begin
         // window change restarts the sequence, no new question
         if (st_reg.watchdog_fail_counter != `QA_FAIL_MAX) begin
            st_next.watchdog_fail_counter = st_reg.watchdog_fail_counter + 3'h1;
         end
         st_next.window_config_changed_flag = 1'b1;
         st_next.sequence_error_flag        = 1'b0;
         st_next.time_out                   = 1'b0;
         st_next.answer_early               = 1'b0;
      end else if (final_wr) begin
         st_next.window_config_changed_flag = 1'b0;
         st_next.time_out                   = 1'b0;
         if (good) begin
            if (st_reg.watchdog_fail_counter != `QA_FAIL_RESET) begin
               st_next.watchdog_fail_counter = st_reg.watchdog_fail_counter - 3'h1;
            end
            st_next.question_counter    = st_reg.question_counter + 4'h1;
            st_next.sequence_error_flag = 1'b0;
            st_next.answer_early        = 1'b0;
            if (st_reg.question_counter == `QA_QCNT_WRAP) begin
               st_next.lfsr = lfsr_step(st_reg.lfsr, st_reg.lfsr_poly_select);
            end
         end else begin
            if (st_reg.watchdog_fail_counter != `QA_FAIL_MAX) begin
               st_next.watchdog_fail_counter = st_reg.watchdog_fail_counter + 3'h1;
            end
            st_next.sequence_error_flag = 1'b1;
            st_next.answer_early        = ~win2_active;
         end
      end else if (timeout_evt) begin
         if (st_reg.watchdog_fail_counter != `QA_FAIL_MAX) begin
            st_next.watchdog_fail_counter = st_reg.watchdog_fail_counter + 3'h1;
         end
         st_next.time_out                   = 1'b1;
         st_next.sequence_error_flag        = st_reg.answer_err;
         st_next.answer_early               = 1'b0;
         st_next.window_config_changed_flag = 1'b0;
      end else if (ans_wr) begin
         st_next.answer_err          = err_now;
         st_next.answer_byte_counter = st_reg.answer_byte_counter - 2'b01;
      end

      if (cfg_wr | final_wr | timeout_evt) begin
         st_next.answer_byte_counter = `QA_ANS_CNT_START;
         st_next.answer_err          = 1'b0;
         st_next.seq_start           = 1'b1;
      end

      if (lbist_done) begin
         st_next.question_counter = `QA_QCNT_RESET;
         st_next.lfsr             = `QA_LFSR_RESET;
      end
      // question output registered so the port comes from a flip-flop
      st_next.question_out = st_next.question_counter ^ st_next.lfsr;
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_reg                     <= '0;
         st_reg.answer_byte_counter <= `QA_ANS_CNT_START;
      end else begin
         st_reg <= st_next;
      end
   end

   assign apb_rsp    = st_reg.rsp;
   assign seq_start  = st_reg.seq_start;
   assign fail_count = st_reg.watchdog_fail_counter;
   assign question   = st_reg.question_out;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_ans_cnt_dec: assert property (
      ans_wr && !final_wr && !cfg_wr && !timeout_evt |=>
         st_reg.answer_byte_counter == $past(st_reg.answer_byte_counter) - 2'b01)
      else $error("answer byte counter did not decrement");

   chk_ans_cnt_reload: assert property (
      final_wr |=> st_reg.answer_byte_counter == 2'b11 && !st_reg.answer_err)
      else $error("answer byte counter not reloaded after final byte");

   chk_ref_default: assert property (
      question_now == 4'h1 && st_reg.answer_byte_counter == 2'b11 |-> ref_byte == 8'hb0)
      else $error("reference byte wrong for question one");

   chk_good_question: assert property (
      good && !cfg_wr && !lbist_done |=> st_reg.question_counter == $past(st_reg.question_counter) + 4'h1
         && !st_reg.sequence_error_flag && !st_reg.answer_early ##0 st_reg.seq_start)
      else $error("good sequence did not advance question");

   chk_bad_keeps_q: assert property (
      final_wr && !good && !cfg_wr && !lbist_done |=> $stable(st_reg.question_counter)
         && st_reg.sequence_error_flag && st_reg.answer_early == !$past(win2_active))
      else $error("bad sequence changed question or flags wrong");

   chk_timeout_flags: assert property (
      timeout_evt && !final_wr && !cfg_wr |=> st_reg.time_out && !st_reg.answer_early
         && st_reg.sequence_error_flag == $past(st_reg.answer_err))
      else $error("time-out flags wrong");

   chk_cfg_flags: assert property (
      cfg_wr |=> st_reg.window_config_changed_flag && !st_reg.sequence_error_flag
         && !st_reg.time_out && !st_reg.answer_early)
      else $error("config change flags wrong");

   chk_lfsr_steps: assert property (
      $changed(st_reg.lfsr) |-> $past(lbist_done) || $past(good && st_reg.question_counter == 4'hf))
      else $error("lfsr moved without counter wrap");

   chk_lbist_clear: assert property (
      lbist_done |=> st_reg.question_counter == 4'h0 && st_reg.lfsr == 4'h0)
      else $error("self-test completion did not clear question");

   chk_err_sticky: assert property (
      st_reg.answer_err && ans_wr && !final_wr && !cfg_wr && !timeout_evt |=> st_reg.answer_err)
      else $error("answer error lost within sequence");

   chk_fail_up: assert property (
      timeout_evt && !final_wr && !cfg_wr && st_reg.watchdog_fail_counter != 3'h7 |=>
         st_reg.watchdog_fail_counter == $past(st_reg.watchdog_fail_counter) + 3'h1)
      else $error("fail counter did not count time-out");

   chk_fail_down: assert property (
      good && !cfg_wr && st_reg.watchdog_fail_counter != 3'h0 |=>
         st_reg.watchdog_fail_counter == $past(st_reg.watchdog_fail_counter) - 3'h1)
      else $error("fail counter did not count good sequence");

   chk_bad_fail_up: assert property (
      final_wr && !good && !cfg_wr && st_reg.watchdog_fail_counter != 3'h7 |=>
         st_reg.watchdog_fail_counter == $past(st_reg.watchdog_fail_counter) + 3'h1)
      else $error("fail counter did not count bad sequence");

   chk_cfg_fail_up: assert property (
      cfg_wr && st_reg.watchdog_fail_counter != 3'h7 |=>
         st_reg.watchdog_fail_counter == $past(st_reg.watchdog_fail_counter) + 3'h1)
      else $error("fail counter did not count window change");

   chk_early_flags: assert property (
      final_wr && !win2_active && !cfg_wr |=> st_reg.answer_early && st_reg.sequence_error_flag)
      else $error("early answer flags wrong");

   chk_value_flags: assert property (
      final_wr && err_now && win2_active && !cfg_wr |=> st_reg.sequence_error_flag && !st_reg.answer_early)
      else $error("wrong value flags wrong");

   chk_tout_keeps_q: assert property (
      timeout_evt && !final_wr && !cfg_wr && !lbist_done |=> $stable(st_reg.question_counter) && $stable(st_reg.lfsr))
      else $error("time-out changed question");

   chk_seq_start: assert property (
      cfg_wr || final_wr || timeout_evt |=> st_reg.seq_start && st_reg.answer_byte_counter == 2'b11)
      else $error("sequence did not restart");

   chk_no_start: assert property (
      !cfg_wr && !final_wr && !timeout_evt |=> !st_reg.seq_start)
      else $error("sequence start without end event");

   chk_err_track: assert property (
      ans_wr && !final_wr && !cfg_wr && !timeout_evt |=> st_reg.answer_err == $past(err_now))
      else $error("answer error not updated");

   chk_ref_first: assert property (
      question_now == 4'h0 && st_reg.answer_byte_counter == 2'b11 |-> ref_byte == 8'hff)
      else $error("reference byte wrong for question zero");

   chk_ref_last: assert property (
      question_now == 4'h1 && st_reg.answer_byte_counter == 2'b00 |-> ref_byte == 8'h4f)
      else $error("last reference byte wrong for question one");

   chk_pready_pulse: assert property (
      st_reg.rsp.pready |=> !st_reg.rsp.pready)
      else $error("ready held longer than one cycle");

   chk_final_clears: assert property (
      final_wr && !cfg_wr |=> !st_reg.window_config_changed_flag && !st_reg.time_out)
      else $error("final byte left stale flags");

   cov_good:    cover property (good);
   cov_early:   cover property (final_wr && !win2_active);
   cov_timeout: cover property (timeout_evt && st_reg.answer_byte_counter == 2'b00);
   cov_cfg:     cover property (cfg_wr);
   cov_value:   cover property (final_wr && err_now && win2_active);

endmodule : qa_watchdog_answer_checker

// File: core/qa_wd_params.svh
/*
 * register offsets, field positions, reset values of the question-and-answer watchdog checker.
 * assumes a 32-bit apb slave with byte addresses and one aligned word per register.
 */
`ifndef QA_WD_PARAMS_SVH
`define QA_WD_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define QA_OFS_FEEDBACK        8'h00
`define QA_OFS_QUESTION        8'h04
`define QA_OFS_ANSWER          8'h08
`define QA_OFS_STATUS          8'h0c
`define QA_OFS_FAIL            8'h10
`define QA_OFS_WIN1            8'h14
`define QA_OFS_WIN2            8'h18

// ************************************************************
// field positions
// ************************************************************
`define QA_LFSR_POLY_SELECT_LSB            1
`define QA_LFSR_POLY_SELECT_MSB            2
`define QA_ST_EARLY            0
`define QA_ST_TOUT             1
`define QA_ST_SEQUENCE_ERROR_FLAG          2
`define QA_ST_CFG_CHG          3
`define QA_ST_ANS_ERR          4
`define QA_ST_CNT_LSB          5
`define QA_ST_CNT_MSB          6

// ************************************************************
// reset and special values
// ************************************************************
`define QA_ANS_CNT_START       2'b11
`define QA_ANS_CNT_LAST        2'b00
`define QA_LFSR_RESET          4'h0
`define QA_LFSR_ZERO_SUB       4'h1
`define QA_QCNT_RESET          4'h0
`define QA_QCNT_WRAP           4'hf
`define QA_FAIL_RESET          3'h0
`define QA_FAIL_MAX            3'h7
`define QA_WIN_RESET           8'h00
`define QA_POLY_X4X3           2'b00
`define QA_POLY_X4X2           2'b01
`define QA_POLY_X3X2           2'b10
`define QA_POLY_X4X3X2         2'b11

`endif

// File: core/qa_wd_pkg.sv
/*
 * types of the question-and-answer watchdog checker: apb carriers and the module state.
 * assumes nothing beyond a systemverilog compiler.
 */
package qa_wd_pkg;

   // ************************************************************
   // apb carriers
   // ************************************************************
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   // ************************************************************
   // checker state
   // ************************************************************
   typedef struct packed {
      logic [3:0] lfsr;
      logic [3:0] question_counter;
      logic [1:0] answer_byte_counter;
      logic       answer_err;
      logic       sequence_error_flag;
      logic       answer_early;
      logic       time_out;
      logic       window_config_changed_flag;
      logic [2:0] watchdog_fail_counter;
      logic [1:0] lfsr_poly_select;
      logic [7:0] first_window_duration_config;
      logic [7:0] second_window_duration_config;
      logic [7:0] answer_write_field;
      logic       seq_start;
      logic [3:0] question_out;
      apb_rsp_t   rsp;
   } wd_state_t;

endpackage : qa_wd_pkg

// File: sim/mcu_answer_model.sv
/*
 * microcontroller model: apb master that reads status and writes watchdog answer bytes.
 * assumes the checker answers every access with pready; waits without limit, the bench cuts hangs.
 */
`timescale 1ns/1ps
`include "qa_wd_params.svh"

module mcu_answer_model
   import qa_wd_pkg::*;
(
   input  wire logic     core_clk,
   output apb_req_t      apb_req,
   input  wire apb_rsp_t apb_rsp
);
   // ************************************************************
   // answer table, byte 3 in the top bits
   // ************************************************************
   localparam logic [31:0] ANS_TABLE [16] = '{
      32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959, 32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3,
      32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474, 32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};

   initial apb_req = '0;

   // ************************************************************
   // bus cycles
   // ************************************************************
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata, output logic err);
      @(posedge core_clk);
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= wr;
      apb_req.paddr   <= addr;
      apb_req.pwdata  <= wdata;
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
      rdata = apb_rsp.prdata;
      err   = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      apb_req.pwdata  <= ~wdata;
   endtask : apb_xfer

   // n bytes in order from counter 11b down; byte at counter value bad is corrupted
   task automatic answer_bytes(input logic [3:0] q, input int n, input logic [2:0] bad);
      logic [31:0] rd;
      logic        er;
      for (int c = 3; c > 3 - n; c--) begin
         apb_xfer(1'b1, `QA_OFS_ANSWER, {24'h0, ANS_TABLE[q][c*8 +: 8] ^ ((c == bad) ? 8'h5a : 8'h00)}, rd, er);
      end
   endtask : answer_bytes
endmodule : mcu_answer_model

// File: sim/qa_watchdog_answer_checker_tb.sv
/*
 * self-checking bench of the question-and-answer watchdog checker.
 * assumes the microcontroller model drives apb; the bench drives window, time-out and self-test inputs.
 */
`timescale 1ns/1ps
`include "qa_wd_params.svh"

module qa_watchdog_answer_checker_tb
   import qa_wd_pkg::*;
();
   typedef struct packed {
      logic [1:0] kind;
      logic [2:0] nbytes;
      logic [2:0] bad;
      logic       win2;
      logic [3:0] exp_st;
   } row_t;
   // kind 0 answers, 1 answers then time-out, 2 window1 write, 3 window2 write; bad 4 = none
   localparam row_t ROWS [11] = '{
      '{2'd2, 3'd0, 3'd4, 1'b1, 4'b1000}, '{2'd0, 3'd4, 3'd4, 1'b0, 4'b0101}, '{2'd0, 3'd4, 3'd0, 1'b1, 4'b0100},
      '{2'd0, 3'd4, 3'd3, 1'b0, 4'b0101}, '{2'd1, 3'd3, 3'd4, 1'b0, 4'b0010}, '{2'd1, 3'd2, 3'd3, 1'b0, 4'b0110},
      '{2'd3, 3'd0, 3'd4, 1'b0, 4'b1000}, '{2'd1, 3'd0, 3'd4, 1'b0, 4'b0010}, '{2'd0, 3'd4, 3'd4, 1'b1, 4'b0000},
      '{2'd0, 3'd4, 3'd1, 1'b1, 4'b0100}, '{2'd0, 3'd4, 3'd4, 1'b1, 4'b0000}};
   localparam row_t GOOD = '{2'd0, 3'd4, 3'd4, 1'b1, 4'b0000};
   localparam logic [7:0]  OFS [7] = '{`QA_OFS_FEEDBACK, `QA_OFS_QUESTION, `QA_OFS_ANSWER, `QA_OFS_STATUS,
                                      `QA_OFS_FAIL, `QA_OFS_WIN1, `QA_OFS_WIN2};
   localparam logic [31:0] RST [7] = '{32'h0, 32'h0, 32'h0, 32'h60, 32'h0, 32'h0, 32'h0};

   logic        core_clk;
   logic        rst_b;
   logic        win2_active;
   logic        timeout_evt;
   logic        lbist_done;
   apb_req_t    apb_req;
   apb_rsp_t    apb_rsp;
   logic        seq_start;
   logic [2:0]  fail_count;
   logic [3:0]  question;
   logic [31:0] rd;
   logic        er;
   logic [3:0]  q_cnt;
   logic [3:0]  lfsr;
   logic [1:0]  sel;
   logic [2:0]  exp_fail;
   int          n_errors = 0;
   int          checks_done = 0;
   int          n_starts = 0;

   // ************************************************************
   // clock, design, partner
   // ************************************************************
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   qa_watchdog_answer_checker u_dut (.core_clk(core_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .win2_active(win2_active), .timeout_evt(timeout_evt), .lbist_done(lbist_done), .seq_start(seq_start),
      .fail_count(fail_count), .question(question));
   mcu_answer_model u_mcu (.core_clk(core_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

   always @(posedge core_clk) if (seq_start === 1'b1) n_starts <= n_starts + 1;

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   function automatic logic [3:0] lfsr_step(input logic [3:0] s, input logic [1:0] p);
      logic [3:0] v;
      v = (s == 4'h0) ? 4'h1 : s;
      case (p)
         2'b00: lfsr_step = {v[2:0], v[3] ^ v[2]};
         2'b01: lfsr_step = {v[2:0], v[3] ^ v[1]};
         2'b10: lfsr_step = {v[2:0], v[2] ^ v[1]};
         default: lfsr_step = {v[2:0], v[3] ^ v[2] ^ v[1]};
      endcase
   endfunction : lfsr_step

   task automatic pulse(input logic lb);
      @(posedge core_clk);
      if (lb) lbist_done <= 1'b1;
      else timeout_evt <= 1'b1;
      @(posedge core_clk);
      lbist_done  <= 1'b0;
      timeout_evt <= 1'b0;
   endtask : pulse

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      q_cnt = 4'h0;
      lfsr = 4'h0;
      sel = 2'b00;
      exp_fail = 3'h0;
      check({24'h0, seq_start, fail_count, question}, 32'h0);
      for (int i = 0; i < 7; i++) begin
         u_mcu.apb_xfer(1'b0, OFS[i], 32'h0, rd, er);
         check(rd, RST[i]);
      end
   endtask : do_reset

   task automatic run_row(input row_t r);
      int n0;
      n0 = n_starts;
      win2_active <= r.win2;
      if (r.kind < 2) u_mcu.answer_bytes(q_cnt ^ lfsr, (r.kind == 0) ? 4 : int'(r.nbytes), r.bad);
      if (r.kind == 1) begin
         u_mcu.apb_xfer(1'b0, `QA_OFS_STATUS, 32'h0, rd, er);
         check({30'h0, rd[6:5]}, 32'(3 - r.nbytes));
         check({31'h0, rd[4]}, {31'h0, r.bad < 3'd4});
         pulse(1'b0);
      end
      if (r.kind >= 2) u_mcu.apb_xfer(1'b1, (r.kind == 2) ? `QA_OFS_WIN1 : `QA_OFS_WIN2, 32'h3c, rd, er);
      if (r.kind == 0 && r.bad == 3'd4 && r.win2) begin
         exp_fail = (exp_fail == 3'h0) ? 3'h0 : exp_fail - 3'h1;
         q_cnt = q_cnt + 4'h1;
         if (q_cnt == 4'h0) lfsr = lfsr_step(lfsr, sel);
      end else begin
         exp_fail = (exp_fail == 3'h7) ? 3'h7 : exp_fail + 3'h1;
      end
      @(posedge core_clk);
      check({28'h0, question}, {28'h0, q_cnt ^ lfsr});
      check({29'h0, fail_count}, {29'h0, exp_fail});
      u_mcu.apb_xfer(1'b0, `QA_OFS_STATUS, 32'h0, rd, er);
      check({26'h0, rd[6:5], rd[3:0]}, {26'h0, 2'b11, r.exp_st});
      u_mcu.apb_xfer(1'b0, `QA_OFS_QUESTION, 32'h0, rd, er);
      check(rd, {28'h0, q_cnt ^ lfsr});
      check(32'(n_starts - n0), 32'h1);
   endtask : run_row

   // ************************************************************
   // stimulus
   // ************************************************************
   initial begin
      rst_b       = 1'b0;
      win2_active = 1'b0;
      timeout_evt = 1'b0;
      lbist_done  = 1'b0;
      do_reset();
      u_mcu.apb_xfer(1'b0, 8'h1c, 32'h0, rd, er);
      check({rd[31:1], er}, 32'h1);
      u_mcu.apb_xfer(1'b1, 8'h1c, 32'h1, rd, er);
      check({31'h0, er}, 32'h1);
      foreach (ROWS[i]) run_row(ROWS[i]);
      pulse(1'b1);
      q_cnt = 4'h0;
      lfsr = 4'h0;
      @(posedge core_clk);
      check({28'h0, question}, 32'h0);
      run_row(GOOD);
      for (int p = 0; p < 4; p++) begin
         sel = 2'(p);
         u_mcu.apb_xfer(1'b1, `QA_OFS_FEEDBACK, {29'h0, sel, 1'b0}, rd, er);
         u_mcu.apb_xfer(1'b0, `QA_OFS_FEEDBACK, 32'h0, rd, er);
         check(rd, {29'h0, sel, 1'b0});
         repeat (16) run_row(GOOD);
      end
      do_reset();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      $display("ERROR %0t watchdog expired", $time);
      close_out();
   end
endmodule : qa_watchdog_answer_checker_tb
